/* File: ptm_checker.sv */
`timescale 1ns/1ps
module ptm_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ptm_pkg::ptm_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic ssp_match_tick,
  input wire logic pwm_match_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire tk = ssp_match_tick;
  a_tick_pair: assert property (tk == pwm_match_tick) else $error("ticks differ");
  a_rd_quiet: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("stray data");
  a_ctl_top: assert property ($past(bus.rd) && $past(bus.addr) == 8'h12 |-> !rdata[7]) else $error("bit7 set");
  a_tick_gap: assert property (tk |=> !tk [*3]) else $error("ticks too close");
  a_cnt_wr: assert property (bus.wr && bus.addr == 8'h11 |=> !tk) else $error("match kept");
  a_run_off: assert property (bus.wr && bus.addr == 8'h12 && !bus.wdata[2] |=> ##1 !tk) else $error("ran");
  a_irq_off: assert property (bus.wr && bus.addr == 8'h8C && !bus.wdata[1] |=> ##1 !irq) else $error("irq");
  // only a write to flags or enables may drop the level
  a_irq_hold: assert property (irq && !(bus.wr && bus.addr[3:0] == 4'hC) |=> irq) else $error("irq fell");
endmodule // ptm_checker

/* File: ptm_period_timer.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - 8-bit counter, software read/write, reset zero
// - count to period, then wrap zero
// - period register read/write, resets all ones
// - match drives 4-bit postscaler, sets flag bit1
// - postscale ratio is field plus one
// - run bit gates counting
// - counter/control writes and reset clear scalers
// - control write keeps counter value
// - raw match offered to serial port
// - raw match offered as pwm time base
// - control bit7 reads zero, others reset zero
module ptm_period_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ptm_pkg::ptm_bus_s bus,
  output logic [ptm_pkg::DATA_W-1:0] rdata,
  output logic irq,
  output logic ssp_match_tick,
  output logic pwm_match_tick
);
  import ptm_pkg::*;

  // free-running instruction clock phase
  logic [1:0] iclk_ff;
  logic [1:0] nxt_iclk;
  // scaler counters
  logic [3:0] pre_ff;
  logic [3:0] nxt_pre;
  logic [3:0] post_ff;
  logic [3:0] nxt_post;
  // software visible registers
  logic [DATA_W-1:0] cnt_ff;
  logic [DATA_W-1:0] nxt_cnt;
  logic [DATA_W-1:0] ctl_ff;
  logic [DATA_W-1:0] nxt_ctl;
  logic [DATA_W-1:0] per_ff;
  logic [DATA_W-1:0] nxt_per;
  logic [DATA_W-1:0] flags_ff;
  logic [DATA_W-1:0] nxt_flags;
  logic [DATA_W-1:0] ien_ff;
  logic [DATA_W-1:0] nxt_ien;
  // registered outputs
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;
  logic match_ff;
  logic nxt_match;

  // address decode, one hit per register
  wire hit_cnt = (bus.addr == OFS_COUNTER);
  wire hit_ctl = (bus.addr == OFS_CONTROL);
  wire hit_per = (bus.addr == OFS_PERIOD);
  wire hit_flg = (bus.addr == OFS_FLAGS);
  wire hit_ien = (bus.addr == OFS_IRQ_EN);
  wire hit_any = hit_cnt || hit_ctl || hit_per || hit_flg || hit_ien;
  wire wr_cnt = bus.wr && hit_cnt;
  wire wr_ctl = bus.wr && hit_ctl;
  wire wr_per = bus.wr && hit_per;
  wire wr_flg = bus.wr && hit_flg;
  wire wr_ien = bus.wr && hit_ien;

  // control fields
  wire [1:0] pre_sel = ctl_ff[CTL_PRE_LSB +: 2];
  wire [3:0] post_sel = ctl_ff[CTL_POST_LSB +: 4];
  wire run = ctl_ff[CTL_RUN_BIT];
  // upper bit set selects 16 regardless of lower bit
  wire [3:0] pre_last = (pre_sel == PRE_DIV1) ? PRE_LAST_DIV1 :
                        (pre_sel == PRE_DIV4) ? PRE_LAST_DIV4 : PRE_LAST_DIV16;

  // instruction clock is one sys_clk in four, as the core's own phase
  // the phase is never cleared, so a control write does not shift it
  wire iclk_tick = (iclk_ff == 2'(ICLK_DIV - 1));
  wire pre_wrap = (pre_ff == pre_last);
  wire pre_tick = run && iclk_tick && pre_wrap;
  wire at_period = (cnt_ff == per_ff);
  // a counter write in the same cycle wins and suppresses the match
  wire match = pre_tick && at_period && !wr_cnt;
  wire post_done = match && (post_ff == post_sel);
  wire scaler_clr = wr_cnt || wr_ctl;
  wire [DATA_W-1:0] flag_set = DATA_W'(post_done) << FLAG_MATCH_BIT;
  wire [DATA_W-1:0] irq_sel = DATA_W'(1) << FLAG_MATCH_BIT;

  assign nxt_iclk = iclk_ff + 2'h1;

  always_comb begin
    if (wr_cnt) begin
      nxt_cnt = bus.wdata;
    end else if (!pre_tick) begin
      nxt_cnt = cnt_ff;
    end else if (at_period) begin
      nxt_cnt = RST_COUNTER;
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  // prescaler is held at zero while stopped to save toggling
  always_comb begin
    if (scaler_clr || !run) begin
      nxt_pre = 4'h0;
    end else if (!iclk_tick) begin
      nxt_pre = pre_ff;
    end else if (pre_wrap) begin
      nxt_pre = 4'h0;
    end else begin
      nxt_pre = pre_ff + 4'h1;
    end
  end

  always_comb begin
    if (scaler_clr) begin
      nxt_post = 4'h0;
    end else if (!match) begin
      nxt_post = post_ff;
    end else if (post_done) begin
      nxt_post = 4'h0;
    end else begin
      nxt_post = post_ff + 4'h1;
    end
  end

  always_comb begin
    if (wr_ctl) begin
      nxt_ctl = bus.wdata & CTL_WMASK;
    end else begin
      nxt_ctl = ctl_ff;
    end
  end

  always_comb begin
    if (wr_per) begin
      nxt_per = bus.wdata;
    end else begin
      nxt_per = per_ff;
    end
  end

  always_comb begin
    if (wr_ien) begin
      nxt_ien = bus.wdata;
    end else begin
      nxt_ien = ien_ff;
    end
  end

  // per flag bit: a hardware set beats a same-cycle software clear
  for (genvar b = 0; b < DATA_W; b++) begin : g_flag
    wire sw_bit = wr_flg ? bus.wdata[b] : flags_ff[b];
    assign nxt_flags[b] = sw_bit | flag_set[b];
  end

  // irq follows the next flag and enable values, so it drops with the write
  assign nxt_irq = |(nxt_flags & nxt_ien & irq_sel);
  assign nxt_match = match;

  // unmapped offsets read as zero; reads have no side effects
  wire [DATA_W-1:0] rd_cnt = hit_cnt ? cnt_ff : 8'h00;
  wire [DATA_W-1:0] rd_ctl = hit_ctl ? (ctl_ff & CTL_WMASK) : 8'h00;
  wire [DATA_W-1:0] rd_per = hit_per ? per_ff : 8'h00;
  wire [DATA_W-1:0] rd_flg = hit_flg ? flags_ff : 8'h00;
  wire [DATA_W-1:0] rd_ien = hit_ien ? ien_ff : 8'h00;
  wire [DATA_W-1:0] rd_mux = rd_cnt | rd_ctl | rd_per | rd_flg | rd_ien;
  assign nxt_rdata = (bus.rd && hit_any) ? rd_mux : 8'h00;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      iclk_ff <= 2'h0;
    end else begin
      iclk_ff <= nxt_iclk;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      post_ff <= 4'h0;
    end else begin
      post_ff <= nxt_post;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= RST_COUNTER;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= RST_CONTROL;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_ff <= RST_PERIOD;
    end else begin
      per_ff <= nxt_per;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= RST_FLAGS;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ien_ff <= RST_IRQ_EN;
    end else begin
      ien_ff <= nxt_ien;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= nxt_match;
    end
  end

  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign ssp_match_tick = match_ff;
  assign pwm_match_tick = match_ff;
endmodule // ptm_period_timer

/* File: ptm_period_timer_tb_top.sv */
`timescale 1ns/1ps
module ptm_period_timer_tb_top;
  import ptm_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  logic irq, tk, pwm;
  logic [7:0] rdata;
  ptm_bus_s bus = '0;
  int n_mismatch = 0, tests_run = 0, cyc = 0, t, n;
  ptm_period_timer u_ptm_period_timer (.sys_clk, .rst, .bus, .rdata, .irq,
    .ssp_match_tick(tk), .pwm_match_tick(pwm));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task stop_test;
    $display("mismatches %0d of %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %0t got %0h want %0h", $time, g, e);
    end
  endtask
  task wr(logic [7:0] a, d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    @(posedge sys_clk);
  endtask
  task rd(logic [7:0] a, e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 chk(rdata, e);
    @(posedge sys_clk);
  endtask
  // cycles up to the next match tick
  task gap;
    t = 0;
    do begin
      @(posedge sys_clk);
      #1 t++;
    end while (tk !== 1'b1 && t < 2000);
  endtask
  task t_regs;
    rd(8'h92, 8'hFF);
    rd(8'h11, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h7F);
    wr(8'h92, 8'h03);
  endtask
  task t_pre(int c, int d);
    wr(8'h12, {5'h00, 1'b1, 2'(c)});
    gap;
    gap;
    chk(t, 16 * d);
    chk(pwm, 1'b1);
  endtask
  // counter preset while stopped so the first match comes early
  task t_post;
    wr(8'h12, 8'h08);
    wr(8'h11, 8'h02);
    wr(8'h12, 8'h08);
    rd(8'h11, 8'h02);
    wr(8'h0C, 8'h00);
    wr(8'h8C, 8'h02);
    wr(8'h12, 8'h0C);
    n = 0;
    for (int i = 0; i < 200 && irq !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1 n += tk;
    end
    chk(n, 2);
    wr(8'h8C, 8'h00);
    #1 chk(irq, 1'b0);
    rd(8'h0C, 8'h02);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    t_regs;
    for (int c = 0; c < 4; c++) t_pre(c, c == 0 ? 1 : c == 1 ? 4 : 16);
    t_post;
    stop_test;
  end
endmodule // ptm_period_timer_tb_top
bind ptm_period_timer ptm_checker u_ptm_checker (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .irq(irq),
  .ssp_match_tick(ssp_match_tick), .pwm_match_tick(pwm_match_tick));

/* File: ptm_pkg.sv */
package ptm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h8C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h92;
  localparam logic [DATA_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [DATA_W-1:0] RST_COUNTER = 8'h00;
  localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_IRQ_EN = 8'h00;
  localparam logic [DATA_W-1:0] RST_PERIOD = 8'hFF;
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam int FLAG_MATCH_BIT = 1;
  localparam logic [DATA_W-1:0] CTL_WMASK = 8'h7F;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
  localparam int ICLK_DIV = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ptm_bus_s;
endpackage
